// ### hdl/plrs_sequencer.sv
// Momentary power loss restart sequencer for a motor drive output stage
//
// How it works
// - Mode 0: undervoltage raises the alarm and disables the output at once.
// - Mode 1: undervoltage disables the output, no alarm during the outage.
// - Mode 1: alarm raised when power returns; output stays disabled.
// - Mode 2: below continuous level, start controlled deceleration to stop.
// - Mode 2: alarm raised once the deceleration to stop has finished.
// - Mode 4: save output frequency at undervoltage, then disable output.
// - Mode 4: with run command, restart at the saved frequency.
// - Mode 5: after power returns and run arrives, restart at start frequency.
// - Undervoltage counts as power failure only while running.
// - Wait up to 2 s for run after ready; else cancel restart mode.
// - No restart before the restart delay, counted from the outage, elapses.
`timescale 1ns/100ps
`default_nettype none
module plrs_sequencer #(
  parameter int FREQ_W = plrs_pkg::PLRS_FREQ_W,
  parameter longint RUN_WAIT_CYC = plrs_pkg::PLRS_RUN_WAIT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Configuration
  input wire logic [plrs_pkg::PLRS_MODE_W-1:0] restart_mode_select,
  input wire logic [FREQ_W-1:0] starting_frequency_setting,
  input wire logic [31:0] restart_delay_time,
  // Bus voltage comparators, commands and motor feedback
  input wire logic bus_undervoltage,
  input wire logic bus_below_running_level,
  input wire logic ready_to_run,
  input wire logic run_command,
  input wire logic decel_done,
  input wire logic [FREQ_W-1:0] output_frequency,
  // Outputs
  output logic output_enable,
  output logic decel_request,
  output logic undervoltage_alarm,
  output logic restart_pulse,
  output logic [FREQ_W-1:0] restart_frequency,
  output logic restart_mode_active
);
  import plrs_pkg::*;

  plrs_state_t state, next_state;
  logic [2:0] mode, next_mode;
  logic [31:0] delay_cnt, next_delay_cnt;
  logic [31:0] wait_cnt, next_wait_cnt;
  logic [FREQ_W-1:0] saved_freq, next_saved_freq;
  logic next_alarm, next_restart_pulse;
  logic [FREQ_W-1:0] next_restart_frequency;

  // Reserved codes fall back to immediate trip
  function automatic logic [2:0] plrs_decode(input logic [2:0] code);
    unique case (code)
      PLRS_MODE_TRIP_RECOVER, PLRS_MODE_DECEL, PLRS_MODE_RESTART_SAVED,
      PLRS_MODE_RESTART_START: plrs_decode = code;
      default: plrs_decode = PLRS_MODE_TRIP_NOW;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_mode = mode;
    next_delay_cnt = delay_cnt;
    next_wait_cnt = wait_cnt;
    next_saved_freq = saved_freq;
    next_alarm = undervoltage_alarm;
    next_restart_pulse = 1'b0;
    next_restart_frequency = restart_frequency;
    if (delay_cnt != PLRS_CNT_ZERO) begin
      next_delay_cnt = delay_cnt - 32'h1;
    end
    unique case (state)
      PLRS_IDLE: begin
        // Undervoltage while stopped is not a power failure
        if (run_command && !bus_undervoltage) begin
          next_state = PLRS_RUN;
          next_alarm = 1'b0;
          next_restart_frequency = starting_frequency_setting;
          next_mode = plrs_decode(restart_mode_select);
        end
      end
      PLRS_RUN: begin
        next_mode = plrs_decode(restart_mode_select);
        if (!run_command) begin
          next_state = PLRS_IDLE;
        end else if (next_mode == PLRS_MODE_DECEL) begin
          if (bus_below_running_level) begin
            next_state = PLRS_DECEL;
          end
        end else if (bus_undervoltage) begin
          next_delay_cnt = restart_delay_time;
          if (next_mode == PLRS_MODE_TRIP_NOW) begin
            next_state = PLRS_TRIPPED;
            next_alarm = 1'b1;
          end else begin
            next_state = PLRS_OUTAGE;
            if (next_mode == PLRS_MODE_RESTART_SAVED) begin
              next_saved_freq = output_frequency;
            end
          end
        end
      end
      PLRS_DECEL: begin
        if (decel_done) begin
          next_state = PLRS_TRIPPED;
          next_alarm = 1'b1;
        end
      end
      PLRS_OUTAGE: begin
        if (ready_to_run) begin
          if (mode == PLRS_MODE_TRIP_RECOVER) begin
            next_state = PLRS_TRIPPED;
            next_alarm = 1'b1;
          end else begin
            next_state = PLRS_WAIT_RUN;
            next_wait_cnt = PLRS_CNT_ZERO;
          end
        end
      end
      PLRS_WAIT_RUN: begin
        if (!ready_to_run) begin
          next_state = PLRS_OUTAGE;
        end else if (run_command && delay_cnt == PLRS_CNT_ZERO) begin
          next_state = PLRS_RUN;
          next_restart_pulse = 1'b1;
          if (mode == PLRS_MODE_RESTART_SAVED) begin
            next_restart_frequency = saved_freq;
          end else begin
            next_restart_frequency = starting_frequency_setting;
          end
        end else if (64'(wait_cnt) >= RUN_WAIT_CYC - 1) begin
          next_state = PLRS_IDLE;
        end
        if (!run_command) begin
          next_wait_cnt = wait_cnt + 32'h1;
        end
      end
      PLRS_TRIPPED: begin
        // Trip held until the run command is withdrawn and the bus recovers; alarm clears at the next start
        if (!run_command && !bus_undervoltage) begin
          next_state = PLRS_IDLE;
        end
      end
      default: next_state = PLRS_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= PLRS_IDLE;
      mode <= PLRS_MODE_TRIP_NOW;
      delay_cnt <= PLRS_CNT_ZERO;
      wait_cnt <= PLRS_CNT_ZERO;
      saved_freq <= FREQ_W'(PLRS_FREQ_ZERO);
      undervoltage_alarm <= 1'b0;
      restart_pulse <= 1'b0;
      restart_frequency <= FREQ_W'(PLRS_FREQ_ZERO);
    end else begin
      state <= next_state;
      mode <= next_mode;
      delay_cnt <= next_delay_cnt;
      wait_cnt <= next_wait_cnt;
      saved_freq <= next_saved_freq;
      undervoltage_alarm <= next_alarm;
      restart_pulse <= next_restart_pulse;
      restart_frequency <= next_restart_frequency;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Deceleration keeps the stage on so regenerated energy holds the bus
  assign output_enable = (state == PLRS_RUN) || (state == PLRS_DECEL);
  assign decel_request = (state == PLRS_DECEL);
  assign restart_mode_active = (state == PLRS_OUTAGE) ||
    (state == PLRS_WAIT_RUN);

  ////////////////////////////////////////////////////////////////////////////
  property p_trip_now;
    @(posedge clock) disable iff (reset)
    (state == PLRS_RUN && run_command && bus_undervoltage &&
     plrs_decode(restart_mode_select) == PLRS_MODE_TRIP_NOW)
    |=> undervoltage_alarm && !output_enable;
  endproperty
  a_trip_now: assert property (p_trip_now) else $error("mode 0 no trip");

  property p_no_alarm_outage;
    @(posedge clock) disable iff (reset)
    state == PLRS_OUTAGE |-> !undervoltage_alarm && !output_enable;
  endproperty
  a_no_alarm_outage: assert property (p_no_alarm_outage)
    else $error("alarm during outage");

  property p_recover_alarm;
    @(posedge clock) disable iff (reset)
    (state == PLRS_OUTAGE && mode == PLRS_MODE_TRIP_RECOVER && ready_to_run)
    |=> undervoltage_alarm && !output_enable;
  endproperty
  a_recover_alarm: assert property (p_recover_alarm)
    else $error("mode 1 no alarm on recovery");

  property p_decel_done;
    @(posedge clock) disable iff (reset)
    (state == PLRS_DECEL && decel_done) |=> undervoltage_alarm;
  endproperty
  a_decel_done: assert property (p_decel_done)
    else $error("no alarm after decel");

  property p_saved_restart;
    @(posedge clock) disable iff (reset)
    (restart_pulse && mode == PLRS_MODE_RESTART_SAVED)
    |-> restart_frequency == saved_freq;
  endproperty
  a_saved_restart: assert property (p_saved_restart)
    else $error("wrong saved frequency");

  property p_restart_delay;
    @(posedge clock) disable iff (reset)
    restart_pulse |-> $past(delay_cnt) == PLRS_CNT_ZERO;
  endproperty
  a_restart_delay: assert property (p_restart_delay)
    else $error("restart before delay");

  property p_idle_no_fail;
    @(posedge clock) disable iff (reset)
    (state == PLRS_IDLE && bus_undervoltage) |=> state == PLRS_IDLE;
  endproperty
  a_idle_no_fail: assert property (p_idle_no_fail)
    else $error("failure seen while stopped");

  property p_start_freq;
    @(posedge clock) disable iff (reset)
    (restart_pulse && mode == PLRS_MODE_RESTART_START)
    |-> restart_frequency == $past(starting_frequency_setting);
  endproperty
  a_start_freq: assert property (p_start_freq)
    else $error("wrong start frequency");
endmodule // plrs_sequencer
`default_nettype wire

// ### inc/plrs_pkg.sv
// Package for the power loss restart sequencer
package plrs_pkg;
  localparam int PLRS_MODE_W = 3;
  localparam int PLRS_FREQ_W = 16;
  localparam logic [2:0] PLRS_MODE_TRIP_NOW = 3'h0;
  localparam logic [2:0] PLRS_MODE_TRIP_RECOVER = 3'h1;
  localparam logic [2:0] PLRS_MODE_DECEL = 3'h2;
  localparam logic [2:0] PLRS_MODE_RESTART_SAVED = 3'h4;
  localparam logic [2:0] PLRS_MODE_RESTART_START = 3'h5;
  localparam int PLRS_CLOCK_MHZ = 125;
  // Run command wait after ready-to-run, in milliseconds
  localparam int PLRS_RUN_WAIT_MS = 2000;
  localparam longint PLRS_RUN_WAIT_CYC = longint'(PLRS_RUN_WAIT_MS) * 1000 *
    PLRS_CLOCK_MHZ;
  localparam int PLRS_CNT_W = 32;
  localparam logic [31:0] PLRS_CNT_ZERO = 32'h0;
  localparam logic [15:0] PLRS_FREQ_ZERO = 16'h0;
  typedef enum logic [2:0] {
    PLRS_IDLE,
    PLRS_RUN,
    PLRS_DECEL,
    PLRS_OUTAGE,
    PLRS_WAIT_RUN,
    PLRS_TRIPPED
  } plrs_state_t;
endpackage

// ### sim/plrs_motor.sv
// Motor and output stage model facing the restart sequencer
`timescale 1ns/100ps
`default_nettype none
module plrs_motor #(
  parameter int DECEL_CYC = 6
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // From the sequencer
  input wire logic output_enable,
  input wire logic decel_request,
  // To the sequencer
  output logic [plrs_pkg::PLRS_FREQ_W-1:0] output_frequency,
  output logic decel_done
);
  int cnt;
  always @(posedge clock) begin
    if (reset) begin
      output_frequency <= 16'h1000;
      cnt <= 0;
    end else if (decel_request) begin
      cnt <= cnt + 1;
      output_frequency <= output_frequency - 16'h0010;
    end else begin
      cnt <= 0;
      if (output_enable) begin
        output_frequency <= output_frequency + 16'h0001;
      end
    end
  end
  // Ramp to stop takes a fixed time, never instant
  assign decel_done = decel_request && (cnt >= DECEL_CYC);
endmodule // plrs_motor
`default_nettype wire

// ### sim/test_plrs_sequencer.sv
// Self-checking bench for the power loss restart sequencer
`timescale 1ns/100ps
`default_nettype none
module test_plrs_sequencer;
  import plrs_pkg::*;
  localparam int WAIT_CYC = 20;
  localparam logic [15:0] START_F = 16'h0123;
  logic clock, reset, uv, below, ready, run, oe, dreq, alarm, rpulse;
  logic ractive, ddone;
  logic [2:0] mode;
  logic [15:0] ofreq, rfreq, f;
  int fails, total_checks, n;
  plrs_sequencer #(.FREQ_W(16), .RUN_WAIT_CYC(WAIT_CYC)) i_plrs_sequencer (
    .clock(clock), .reset(reset), .restart_mode_select(mode),
    .starting_frequency_setting(START_F), .restart_delay_time(32'h8),
    .bus_undervoltage(uv), .bus_below_running_level(below),
    .ready_to_run(ready), .run_command(run), .decel_done(ddone),
    .output_frequency(ofreq), .output_enable(oe), .decel_request(dreq),
    .undervoltage_alarm(alarm), .restart_pulse(rpulse),
    .restart_frequency(rfreq), .restart_mode_active(ractive));
  plrs_motor i_plrs_motor (.clock(clock), .reset(reset),
    .output_enable(oe), .decel_request(dreq),
    .output_frequency(ofreq), .decel_done(ddone));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic start(input logic [2:0] m);
    mode = m;
    run = 1'b1;
    tick(2);
    chk(oe, 1'b1);
    chk(rfreq, START_F);
    chk(alarm, 1'b0);
  endtask
  task automatic idle();
    uv = 1'b0;
    run = 1'b0;
    ready = 1'b0;
    below = 1'b0;
    tick(3);
  endtask
  task automatic stop();
    mode = 3'h0;
    uv = 1'b1;
    tick(2);
    idle();
  endtask
  // Wait for a restart under a bound
  task automatic wait_restart();
    n = 0;
    while (rpulse !== 1'b1 && n < 40) begin
      tick(1);
      n++;
    end
    chk(rpulse, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_trip(input logic [2:0] m);
    start(m);
    uv = 1'b1;
    tick(2);
    chk(oe, 1'b0);
    chk(alarm, 1'b1);
    idle();
  endtask
  task automatic t_mode1();
    start(3'h1);
    uv = 1'b1;
    tick(2);
    chk(oe, 1'b0);
    chk(alarm, 1'b0);
    chk(ractive, 1'b1);
    uv = 1'b0;
    ready = 1'b1;
    tick(2);
    chk(alarm, 1'b1);
    chk(oe, 1'b0);
    idle();
  endtask
  task automatic t_mode2();
    start(3'h2);
    below = 1'b1;
    tick(2);
    chk(dreq, 1'b1);
    chk(oe, 1'b1);
    chk(alarm, 1'b0);
    n = 0;
    while (ddone !== 1'b1 && n < 50) begin
      tick(1);
      n++;
    end
    chk(ddone, 1'b1);
    tick(2);
    chk(alarm, 1'b1);
    chk(oe, 1'b0);
    idle();
  endtask
  task automatic t_mode4();
    start(3'h4);
    tick(3);
    uv = 1'b1;
    f = ofreq;
    tick(1);
    chk(oe, 1'b0);
    uv = 1'b0;
    ready = 1'b1;
    wait_restart();
    chk(n >= 8, 1'b1);
    chk(rfreq, f);
    chk(oe, 1'b1);
    stop();
  endtask
  task automatic t_mode5(input logic late);
    start(3'h5);
    uv = 1'b1;
    tick(1);
    // Run drops a cycle after the bus, as a sagging relay supply would
    run = 1'b0;
    tick(1);
    uv = 1'b0;
    ready = 1'b1;
    tick(late ? WAIT_CYC + 12 : 12);
    chk(oe, 1'b0);
    chk(ractive, !late);
    run = 1'b1;
    if (late) begin
      tick(2);
      chk(oe, 1'b1);
      chk(rfreq, START_F);
    end else begin
      wait_restart();
      chk(rfreq, START_F);
    end
    stop();
  endtask
  // Undervoltage with run asserted while stopped must not start anything
  task automatic t_stopped_uv();
    mode = 3'h4;
    uv = 1'b1;
    run = 1'b1;
    tick(4);
    chk(oe, 1'b0);
    chk(ractive, 1'b0);
    chk(alarm, 1'b0);
    idle();
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("fails %0d checks %0d", fails, total_checks);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    tick(3000);
    fails++;
    end_sim();
  end
  initial begin
    {reset, uv, below, ready, run, mode} = 8'h80;
    fails = 0;
    total_checks = 0;
    repeat (10) @(posedge clock);
    #1;
    reset = 1'b0;
    tick(1);
    t_stopped_uv();
    t_trip(3'h0);
    t_trip(3'h3);
    t_trip(3'h6);
    t_trip(3'h7);
    t_mode1();
    t_mode2();
    t_mode4();
    t_mode5(1'b0);
    t_mode5(1'b1);
    end_sim();
  end
endmodule // test_plrs_sequencer
`default_nettype wire
